// >>> rtl/pov_pkg.sv
// Constants and carrier types for the port override and pin register block
// Overview of operation
// - Port D bit 0 feeds the timer2 capture input; software keeps it input.
// - Port D bit 0 level also goes out as pin-change source 16.
// - Timer2 mode 0b1001 forces port D bit 7 to input for serial data.
// - All clock mode bits and both selects set force port D bit 4 input.
// - Timer2 output two drives port D bit 6, output one drives bit 5.
// - Bit 3 input buffer forced on by pin change group or interrupt one.
// - Bit 2 input buffer forced on by pin change group or interrupt zero.
// - Global pull-up disable set turns off every pull-up of every port.
// - Control register bits 4, 1, 0 read/write; others read zero; reset zero.
// - Port B output data: eight read/write bits, reset to zero.
// - Port B direction: eight read/write bits, reset to zero.
// - Port B pin input: eight bits, one per pin, initial value zero.
// - Port C output data: bits 2..0 read/write, upper bits read zero.
// - Port C direction: bits 2..0 read/write, upper bits read zero.
package pov_pkg;
  // Word offsets on the bus, byte addresses
  localparam logic [7:0] POV_OFS_MCU_CONTROL = 8'h00;
  localparam logic [7:0] POV_OFS_PB_DATA     = 8'h04;
  localparam logic [7:0] POV_OFS_PB_DIR      = 8'h08;
  localparam logic [7:0] POV_OFS_PB_PIN      = 8'h0c;
  localparam logic [7:0] POV_OFS_PC_DATA     = 8'h10;
  localparam logic [7:0] POV_OFS_PC_DIR      = 8'h14;
  localparam logic [7:0] POV_OFS_PC_PIN      = 8'h18;
  localparam logic [7:0] POV_OFS_IRQ_STATUS  = 8'h1c;
  localparam logic [7:0] POV_OFS_IRQ_MASK    = 8'h20;
  // Control register fields
  localparam int         POV_PUD_BIT         = 4;
  localparam int         POV_VSEL_BIT        = 1;
  localparam int         POV_VCE_BIT         = 0;
  localparam logic [7:0] POV_MCU_RW_MASK     = 8'h13;
  localparam logic [7:0] POV_PC_RW_MASK      = 8'h07;
  localparam logic [7:0] POV_REG_RESET       = 8'h00;
  localparam int         POV_PC_W            = 3;
  // Override conditions
  localparam logic [3:0] POV_T2_MODE_SPI     = 4'h9;
  localparam logic [1:0] POV_CMM_EXT         = 2'h3;
  // Interrupt status layout
  localparam int         POV_IRQ_W           = 3;
  localparam int         POV_IRQ_PB          = 0;
  localparam int         POV_IRQ_PC          = 1;
  localparam int         POV_IRQ_PD          = 2;

  typedef struct packed {
    logic port_value_override_enable;
    logic port_value_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pov_ovr_t;

  localparam pov_ovr_t POV_OVR_NONE = '0;

  typedef struct packed {
    logic [1:0] clock_mode_bits;
    logic       external_clock_select;
    logic       clock_source_select;
  } pov_clk_cfg_t;
endpackage

// >>> rtl/pov_pin_cell.sv
// One port pin: override muxing of direction, value and input buffer; pull-up from data and direction
`timescale 1ns/1ns
`default_nettype none
module pov_pin_cell
  import pov_pkg::*;
(
  input  wire logic     data_i,
  input  wire logic     dir_i,
  input  wire logic     pud_i,
  input  wire logic     sleep_i,
  input  wire logic     pad_i,
  input  wire pov_ovr_t ovr_i,
  output logic          pad_o,
  output logic          pad_oe_o,
  output logic          pullup_o,
  output logic          in_o
);
  logic dir_eff;
  logic buf_en;

  assign dir_eff  = ovr_i.direction_override_enable ? ovr_i.direction_override_value : dir_i;
  assign pad_oe_o = dir_eff;
  assign pad_o    = ovr_i.port_value_override_enable ? ovr_i.port_value_override_value : data_i;
  // Pull-up only on an input with data one; never overridden
  assign pullup_o = ~dir_eff & data_i & ~pud_i;
  // Buffer off in sleep unless an alternate function needs the level
  assign buf_en   = ovr_i.input_enable_override_enable ? ovr_i.input_enable_override_value : ~sleep_i;
  assign in_o     = pad_i & buf_en;
endmodule
`default_nettype wire

// >>> rtl/pov_irq.sv
// Sticky pin-change status with mask and read-to-clear
`timescale 1ns/1ns
`default_nettype none
module pov_irq
  import pov_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic [POV_IRQ_W-1:0] event_i,
  input  wire logic                 status_rd_i,
  input  wire logic                 mask_wr_i,
  input  wire logic [POV_IRQ_W-1:0] mask_i,
  output logic      [POV_IRQ_W-1:0] status_o,
  output logic      [POV_IRQ_W-1:0] mask_o,
  output logic                      irq_o
);
  logic [POV_IRQ_W-1:0] status_r;
  logic [POV_IRQ_W-1:0] mask_r;

  // New events win over the read that clears the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= '0;
    end else if (ce_i) begin
      status_r <= (status_rd_i ? '0 : status_r) | event_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= '0;
    end else if (ce_i && mask_wr_i) begin
      mask_r <= mask_i;
    end
  end

  assign status_o = status_r;
  assign mask_o   = mask_r;
  assign irq_o    = |(status_r & mask_r);

  a_event_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && event_i[POV_IRQ_PB] |=> status_r[POV_IRQ_PB])
    else $error("pin change event lost");
  c_irq_raised: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(irq_o));
endmodule
`default_nettype wire

// >>> rtl/pov_top.sv
// Port B/C registers, global pull-up disable and port D override logic
`timescale 1ns/1ns
`default_nettype none
module pov_top
  import pov_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  // Wishbone classic slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  output logic               irq_o,
  // Control register outputs and sleep input
  output logic               vector_table_select_o,
  output logic               vector_change_enable_o,
  input  wire logic          sleep_i,
  // Port B pins
  input  wire logic [7:0]    port_b_pad_i,
  output logic      [7:0]    port_b_pad_o,
  output logic      [7:0]    port_b_pad_oe_o,
  output logic      [7:0]    port_b_pullup_o,
  // Port C pins
  input  wire logic [2:0]    port_c_pad_i,
  output logic      [2:0]    port_c_pad_o,
  output logic      [2:0]    port_c_pad_oe_o,
  output logic      [2:0]    port_c_pullup_o,
  // Port D registers live elsewhere
  input  wire logic [7:0]    port_d_data_i,
  input  wire logic [7:0]    port_d_dir_i,
  input  wire logic [7:0]    port_d_pad_i,
  output logic      [7:0]    port_d_pad_o,
  output logic      [7:0]    port_d_pad_oe_o,
  output logic      [7:0]    port_d_pullup_o,
  // Peripheral controls
  input  wire logic [3:0]    timer2_mode_field_i,
  input  wire logic          timer2_output_one_i,
  input  wire logic          timer2_output_one_en_i,
  input  wire logic          timer2_output_two_i,
  input  wire logic          timer2_output_two_en_i,
  input  wire pov_clk_cfg_t  clk_cfg_i,
  input  wire logic [7:0]    pin_change_select_i,
  input  wire logic          port_d_pin_change_group_enable_i,
  input  wire logic          external_interrupt_zero_en_i,
  input  wire logic          external_interrupt_one_en_i,
  // Levels handed to peripherals
  output logic               timer2_capture_input_o,
  output logic      [7:0]    pin_change_source_o,
  output logic               serial_data_input_o,
  output logic               external_clock_input_one_o,
  output logic               external_interrupt_zero_o,
  output logic               external_interrupt_one_o,
  output logic               timer_external_clock_input_o
);
  logic [7:0]           mcu_control_r;
  logic [7:0]           port_b_output_data_r;
  logic [7:0]           port_b_direction_r;
  logic [7:0]           port_b_pin_input_r;
  logic [POV_PC_W-1:0]  port_c_output_data_r;
  logic [POV_PC_W-1:0]  port_c_direction_r;
  logic [POV_PC_W-1:0]  port_c_pin_input_r;
  logic [7:0]           port_d_pin_r;
  logic                 ack_r;
  logic [31:0]          dat_r;
  logic [7:0]           rd_nxt;
  logic                 global_pullup_disable;
  logic                 wr_go;
  logic                 rd_go;
  logic [7:0]           wbyte;
  logic [7:0]           pb_in;
  logic [POV_PC_W-1:0]  pc_in;
  logic [7:0]           pd_in;
  pov_ovr_t             pd_ovr [8];
  logic [POV_IRQ_W-1:0] irq_evt;
  logic [POV_IRQ_W-1:0] irq_status;
  logic [POV_IRQ_W-1:0] irq_mask;
  logic                 irq_clr;
  logic [POV_IRQ_W-1:0] irq_keep;

  // Bus handshake: ack one cycle after the request; writes and read-clear at ack edge, read data captured at the request edge
  assign wr_go = cyc_i & stb_i & we_i & ack_r & sel_i[0] & ce_i;
  assign rd_go = cyc_i & stb_i & ~we_i & ack_r & ce_i;
  assign wbyte = dat_i[7:0];
  assign global_pullup_disable   = mcu_control_r[POV_PUD_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= cyc_i & stb_i & ~ack_r;
    end
  end

  // Unmapped offsets read zero and ignore writes
  always_comb begin
    rd_nxt = 8'h00;
    case (adr_i)
      POV_OFS_MCU_CONTROL: rd_nxt = mcu_control_r & POV_MCU_RW_MASK;
      POV_OFS_PB_DATA:     rd_nxt = port_b_output_data_r;
      POV_OFS_PB_DIR:      rd_nxt = port_b_direction_r;
      POV_OFS_PB_PIN:      rd_nxt = port_b_pin_input_r;
      POV_OFS_PC_DATA:     rd_nxt = {5'h00, port_c_output_data_r};
      POV_OFS_PC_DIR:      rd_nxt = {5'h00, port_c_direction_r};
      POV_OFS_PC_PIN:      rd_nxt = {5'h00, port_c_pin_input_r};
      POV_OFS_IRQ_STATUS:  rd_nxt = {5'h00, irq_status};
      POV_OFS_IRQ_MASK:    rd_nxt = {5'h00, irq_mask};
      default:             rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (ce_i && cyc_i && stb_i && !ack_r) begin
      dat_r <= {24'h00_0000, rd_nxt};
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // Only the documented bits hold state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcu_control_r <= POV_REG_RESET;
    end else if (wr_go && adr_i == POV_OFS_MCU_CONTROL) begin
      mcu_control_r <= wbyte & POV_MCU_RW_MASK;
    end
  end

  assign vector_table_select_o  = mcu_control_r[POV_VSEL_BIT];
  assign vector_change_enable_o = mcu_control_r[POV_VCE_BIT];

  // Writing ones to the pin register toggles the data bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_b_output_data_r <= POV_REG_RESET;
    end else if (wr_go && adr_i == POV_OFS_PB_DATA) begin
      port_b_output_data_r <= wbyte;
    end else if (wr_go && adr_i == POV_OFS_PB_PIN) begin
      port_b_output_data_r <= port_b_output_data_r ^ wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_b_direction_r <= POV_REG_RESET;
    end else if (wr_go && adr_i == POV_OFS_PB_DIR) begin
      port_b_direction_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_c_output_data_r <= POV_REG_RESET[POV_PC_W-1:0];
    end else if (wr_go && adr_i == POV_OFS_PC_DATA) begin
      port_c_output_data_r <= wbyte[POV_PC_W-1:0];
    end else if (wr_go && adr_i == POV_OFS_PC_PIN) begin
      port_c_output_data_r <= port_c_output_data_r ^ wbyte[POV_PC_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_c_direction_r <= POV_REG_RESET[POV_PC_W-1:0];
    end else if (wr_go && adr_i == POV_OFS_PC_DIR) begin
      port_c_direction_r <= wbyte[POV_PC_W-1:0];
    end
  end

  // Pin samples; a change against the last sample is an event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_b_pin_input_r <= POV_REG_RESET;
      port_c_pin_input_r <= POV_REG_RESET[POV_PC_W-1:0];
      port_d_pin_r       <= POV_REG_RESET;
    end else if (ce_i) begin
      port_b_pin_input_r <= pb_in;
      port_c_pin_input_r <= pc_in;
      port_d_pin_r       <= pd_in;
    end
  end

  assign irq_evt[POV_IRQ_PB] = |(pb_in ^ port_b_pin_input_r);
  assign irq_evt[POV_IRQ_PC] = |(pc_in ^ port_c_pin_input_r);
  assign irq_evt[POV_IRQ_PD] = |(pd_in ^ port_d_pin_r);

  // Read data was captured one edge before the clear; bits set since then
  // were never seen by software and must survive the clear
  assign irq_clr  = rd_go && adr_i == POV_OFS_IRQ_STATUS;
  assign irq_keep = irq_status & ~dat_r[POV_IRQ_W-1:0] & {POV_IRQ_W{irq_clr}};

  pov_irq u_irq (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .event_i     (irq_evt | irq_keep),
    .status_rd_i (irq_clr),
    .mask_wr_i   (wr_go && adr_i == POV_OFS_IRQ_MASK),
    .mask_i      (wbyte[POV_IRQ_W-1:0]),
    .status_o    (irq_status),
    .mask_o      (irq_mask),
    .irq_o       (irq_o)
  );

  // Port B and C have no alternate functions in this block
  for (genvar i = 0; i < 8; i++) begin : g_pb
    pov_pin_cell u_cell (
      .data_i   (port_b_output_data_r[i]),
      .dir_i    (port_b_direction_r[i]),
      .pud_i    (global_pullup_disable),
      .sleep_i  (sleep_i),
      .pad_i    (port_b_pad_i[i]),
      .ovr_i    (POV_OVR_NONE),
      .pad_o    (port_b_pad_o[i]),
      .pad_oe_o (port_b_pad_oe_o[i]),
      .pullup_o (port_b_pullup_o[i]),
      .in_o     (pb_in[i])
    );
  end

  for (genvar i = 0; i < POV_PC_W; i++) begin : g_pc
    pov_pin_cell u_cell (
      .data_i   (port_c_output_data_r[i]),
      .dir_i    (port_c_direction_r[i]),
      .pud_i    (global_pullup_disable),
      .sleep_i  (sleep_i),
      .pad_i    (port_c_pad_i[i]),
      .ovr_i    (POV_OVR_NONE),
      .pad_o    (port_c_pad_o[i]),
      .pad_oe_o (port_c_pad_oe_o[i]),
      .pullup_o (port_c_pullup_o[i]),
      .in_o     (pc_in[i])
    );
  end

  // Port D override table; pull-up override never enabled
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pd_ovr[i]       = POV_OVR_NONE;
      pd_ovr[i].input_enable_override_value = 1'b1;
      pd_ovr[i].input_enable_override_enable = pin_change_select_i[i] &
                        port_d_pin_change_group_enable_i;
    end
    pd_ovr[7].direction_override_enable = (timer2_mode_field_i == POV_T2_MODE_SPI);
    pd_ovr[6].port_value_override_enable = timer2_output_two_en_i;
    pd_ovr[6].port_value_override_value = timer2_output_two_i;
    pd_ovr[5].port_value_override_enable = timer2_output_one_en_i;
    pd_ovr[5].port_value_override_value = timer2_output_one_i;
    pd_ovr[4].direction_override_enable = (clk_cfg_i.clock_mode_bits == POV_CMM_EXT) & clk_cfg_i.external_clock_select &
                     clk_cfg_i.clock_source_select;
    pd_ovr[3].input_enable_override_enable |= external_interrupt_one_en_i;
    pd_ovr[2].input_enable_override_enable |= external_interrupt_zero_en_i;
  end

  for (genvar i = 0; i < 8; i++) begin : g_pd
    pov_pin_cell u_cell (
      .data_i   (port_d_data_i[i]),
      .dir_i    (port_d_dir_i[i]),
      .pud_i    (global_pullup_disable),
      .sleep_i  (sleep_i),
      .pad_i    (port_d_pad_i[i]),
      .ovr_i    (pd_ovr[i]),
      .pad_o    (port_d_pad_o[i]),
      .pad_oe_o (port_d_pad_oe_o[i]),
      .pullup_o (port_d_pullup_o[i]),
      .in_o     (pd_in[i])
    );
  end

  // Peripheral levels come from the sampled pins, one cycle late
  assign timer2_capture_input_o       = port_d_pin_r[0];
  assign pin_change_source_o          = port_d_pin_r;
  assign timer_external_clock_input_o = port_d_pin_r[1];
  assign external_interrupt_zero_o    = port_d_pin_r[2];
  assign external_interrupt_one_o     = port_d_pin_r[3];
  assign external_clock_input_one_o   = port_d_pin_r[4];
  assign serial_data_input_o          = port_d_pin_r[7];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_spi_dir_force: assert property (
    timer2_mode_field_i == POV_T2_MODE_SPI |-> !port_d_pad_oe_o[7])
    else $error("port D bit 7 not forced to input in serial mode");
  a_eclk_dir_force: assert property (
    clk_cfg_i == {POV_CMM_EXT, 2'b11} |-> !port_d_pad_oe_o[4])
    else $error("port D bit 4 not forced to input for clock");
  a_timer2_output_two_drive: assert property (
    timer2_output_two_en_i |-> port_d_pad_o[6] == timer2_output_two_i)
    else $error("timer2 output two not on port D bit 6");
  a_timer2_output_one_plain: assert property (
    !timer2_output_one_en_i |-> port_d_pad_o[5] == port_d_data_i[5])
    else $error("port D bit 5 value overridden without enable");
  a_pud_all_off: assert property (
    global_pullup_disable |-> port_b_pullup_o == 8'h00 && port_c_pullup_o == 3'h0 &&
            port_d_pullup_o == 8'h00)
    else $error("pull-up active while globally disabled");
  a_mcu_read_mask: assert property (
    ack_o && !we_i && adr_i == POV_OFS_MCU_CONTROL |->
    (dat_o[7:0] & ~POV_MCU_RW_MASK) == 8'h00)
    else $error("reserved control bits read nonzero");
  a_pb_write_lands: assert property (
    wr_go && adr_i == POV_OFS_PB_DATA |=> port_b_output_data_r ==
    $past(wbyte))
    else $error("port B data write lost");
  a_pc_dir_upper: assert property (
    ack_o && !we_i && adr_i == POV_OFS_PC_DIR |-> dat_o[7:3] == 5'h00)
    else $error("port C direction upper bits nonzero");
  a_pb_pin_sample: assert property (
    ce_i && !sleep_i |=> port_b_pin_input_r == $past(port_b_pad_i))
    else $error("port B pin sample wrong");
  a_capture_path: assert property (
    ce_i && !sleep_i |=> timer2_capture_input_o == $past(port_d_pad_i[0]))
    else $error("capture input does not follow port D bit 0");
  a_external_interrupt_one_buffer: assert property (
    ce_i && sleep_i && external_interrupt_one_en_i |=>
    external_interrupt_one_o == $past(port_d_pad_i[3]))
    else $error("port D bit 3 buffer not forced on");
  a_external_interrupt_zero_buffer: assert property (
    ce_i && sleep_i && external_interrupt_zero_en_i |=>
    external_interrupt_zero_o == $past(port_d_pad_i[2]))
    else $error("port D bit 2 buffer not forced on");

  c_spi_mode: cover property (timer2_mode_field_i == POV_T2_MODE_SPI);
  c_pud_set: cover property ($rose(global_pullup_disable));
  c_pb_toggle: cover property (wr_go && adr_i == POV_OFS_PB_PIN);
endmodule
`default_nettype wire

// >>> testbench/pov_pin_model.sv
// Pin-side model: outside driver, pull-up and pin drive resolved per pin
`timescale 1ns/1ns
`default_nettype none
module pov_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] drv_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] pullup_i,
  input  wire logic [W-1:0] ext_i,
  input  wire logic [W-1:0] ext_oe_i,
  output logic      [W-1:0] pad_o
);
  // Floating pin shows the inverse of the drive value, never a lucky match
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe_i[i]) begin
        pad_o[i] = drv_i[i];
      end else if (ext_oe_i[i]) begin
        pad_o[i] = ext_i[i];
      end else if (pullup_i[i]) begin
        pad_o[i] = 1'b1;
      end else begin
        pad_o[i] = ~drv_i[i];
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_pov_top.sv
// Self-checking bench for the port override and pin register block
`timescale 1ns/1ns
`default_nettype none
module tb_pov_top;
  import pov_pkg::*;
  logic         clk_i = 0, rst_i = 1, sleep_i = 0;
  logic         cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o, vts, vce;
  logic [7:0]   adr_i = '0;
  logic [3:0]   sel_i = '0;
  logic [31:0]  dat_i = '0, dat_o;
  logic [7:0]   pb_ext = '0, pb_eoe = 8'hff, pb_pad, pb_drv, pb_oe, pb_pu;
  logic [2:0]   pc_ext = '0, pc_eoe = 3'h7, pc_pad, pc_drv, pc_oe, pc_pu;
  logic [7:0]   pd_ext = '0, pd_eoe = 8'hff, pd_pad, pd_drv, pd_oe, pd_pu;
  logic [7:0]   pd_data = '0, pd_dir = '0, pc_sel = '0, pcs;
  logic [3:0]   t2_mode = '0;
  logic         timer2_output_one = 0, timer2_output_one_en = 0, timer2_output_two = 0, timer2_output_two_en = 0;
  logic         port_d_pin_change_group_enable = 0, external_interrupt_zero_en = 0, external_interrupt_one_en = 0;
  logic         cap, serial_data_input, external_clock_input_one, ei0, ei1, tclk;
  pov_clk_cfg_t clk_cfg = '0;
  int           mismatches = 0, samples_checked = 0, cycles = 0;
  logic [7:0]   rdat;

  always #20 clk_i = ~clk_i;

  pov_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .vector_table_select_o(vts),
    .vector_change_enable_o(vce), .sleep_i(sleep_i), .port_b_pad_i(pb_pad),
    .port_b_pad_o(pb_drv), .port_b_pad_oe_o(pb_oe), .port_b_pullup_o(pb_pu),
    .port_c_pad_i(pc_pad), .port_c_pad_o(pc_drv), .port_c_pad_oe_o(pc_oe),
    .port_c_pullup_o(pc_pu), .port_d_data_i(pd_data), .port_d_dir_i(pd_dir),
    .port_d_pad_i(pd_pad), .port_d_pad_o(pd_drv), .port_d_pad_oe_o(pd_oe),
    .port_d_pullup_o(pd_pu), .timer2_mode_field_i(t2_mode),
    .timer2_output_one_i(timer2_output_one), .timer2_output_one_en_i(timer2_output_one_en),
    .timer2_output_two_i(timer2_output_two), .timer2_output_two_en_i(timer2_output_two_en),
    .clk_cfg_i(clk_cfg), .pin_change_select_i(pc_sel),
    .port_d_pin_change_group_enable_i(port_d_pin_change_group_enable),
    .external_interrupt_zero_en_i(external_interrupt_zero_en),
    .external_interrupt_one_en_i(external_interrupt_one_en), .timer2_capture_input_o(cap),
    .pin_change_source_o(pcs), .serial_data_input_o(serial_data_input),
    .external_clock_input_one_o(external_clock_input_one), .external_interrupt_zero_o(ei0),
    .external_interrupt_one_o(ei1), .timer_external_clock_input_o(tclk));

  pov_pin_model #(.W(8)) pins_b_u (.drv_i(pb_drv), .oe_i(pb_oe),
    .pullup_i(pb_pu), .ext_i(pb_ext), .ext_oe_i(pb_eoe), .pad_o(pb_pad));
  pov_pin_model #(.W(3)) pins_c_u (.drv_i(pc_drv), .oe_i(pc_oe),
    .pullup_i(pc_pu), .ext_i(pc_ext), .ext_oe_i(pc_eoe), .pad_o(pc_pad));
  pov_pin_model #(.W(8)) pins_d_u (.drv_i(pd_drv), .oe_i(pd_oe),
    .pullup_i(pd_pu), .ext_i(pd_ext), .ext_oe_i(pd_eoe), .pad_o(pd_pad));

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    // Whole run needs about 210 cycles
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; waits for ack, then one idle cycle follows
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= 4'h1;
    // A hang is ended by the cycle ceiling only
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rdat = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk({24'h0, rdat}, {24'h0, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic t_regs();
    logic [7:0] ofs [6] = '{POV_OFS_MCU_CONTROL, POV_OFS_PB_DATA,
      POV_OFS_PB_DIR, POV_OFS_PC_DATA, POV_OFS_PC_DIR, 8'h24};
    logic [7:0] msk [6] = '{POV_MCU_RW_MASK, 8'hff, 8'hff, POV_PC_RW_MASK,
      POV_PC_RW_MASK, 8'h00};
    for (int i = 0; i < 6; i++) rdc(ofs[i], 8'h00);
    rdc(POV_OFS_PB_PIN, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, ofs[i], 8'hff);
      rdc(ofs[i], msk[i]);
      if (i == 0) chk({vts, vce}, 2'b11);
      if (i == 1) chk(pb_drv, 8'hff);
      if (i == 2) chk(pb_oe, 8'hff);
      if (i == 3) chk(pc_drv, 3'h7);
      if (i == 4) chk(pc_oe, 3'h7);
      wb(1'b1, ofs[i], 8'h00);
      rdc(ofs[i], 8'h00);
    end
    // Ones written to a pin register toggle the data bits
    wb(1'b1, POV_OFS_PB_PIN, 8'h3c);
    rdc(POV_OFS_PB_DATA, 8'h3c);
    wb(1'b1, POV_OFS_PB_PIN, 8'h3c);
    rdc(POV_OFS_PB_DATA, 8'h00);
    wb(1'b1, POV_OFS_PC_PIN, 8'h05);
    rdc(POV_OFS_PC_DATA, 8'h05);
    rdc(POV_OFS_PC_PIN, 8'h00);
    wb(1'b1, POV_OFS_PC_PIN, 8'h05);
    rdc(POV_OFS_PC_DATA, 8'h00);
    $display("register access test done");
  endtask

  task automatic t_pullup();
    wb(1'b1, POV_OFS_PB_DATA, 8'hff);
    wb(1'b1, POV_OFS_PC_DATA, 8'h07);
    @(posedge clk_i);
    pb_eoe <= 8'h00;
    pd_data <= 8'hff;
    settle(1);
    chk({pb_pu, 5'h0, pc_pu, pd_pu}, 24'hff07ff);
    wb(1'b1, POV_OFS_MCU_CONTROL, 8'h10);
    settle(1);
    chk({pb_pu, 5'h0, pc_pu, pd_pu}, 24'h0);
    rdc(POV_OFS_PB_PIN, 8'h00);
    wb(1'b1, POV_OFS_MCU_CONTROL, 8'h00);
    settle(1);
    rdc(POV_OFS_PB_PIN, 8'hff);
    pb_eoe <= 8'hff;
    pd_data <= 8'h00;
    wb(1'b1, POV_OFS_PB_DATA, 8'h00);
    wb(1'b1, POV_OFS_PC_DATA, 8'h00);
    $display("pull-up test done");
  endtask

  task automatic t_override();
    @(posedge clk_i);
    pd_dir <= 8'hff;
    pd_ext <= 8'h90;
    t2_mode <= POV_T2_MODE_SPI;
    clk_cfg <= '{clock_mode_bits: 2'h3, external_clock_select: 1'b1, clock_source_select: 1'b1};
    timer2_output_two <= 1'b1;
    timer2_output_two_en <= 1'b1;
    timer2_output_one <= 1'b1;
    settle(2);
    chk(pd_oe, 8'h6f);
    chk(pd_drv & 8'h60, 8'h40);
    chk({serial_data_input, external_clock_input_one}, 2'b11);
    @(posedge clk_i);
    t2_mode <= 4'h8;
    clk_cfg.external_clock_select <= 1'b0;
    timer2_output_one_en <= 1'b1;
    timer2_output_two <= 1'b0;
    settle(1);
    chk(pd_oe, 8'hff);
    chk(pd_drv & 8'h60, 8'h20);
    @(posedge clk_i);
    pd_dir <= 8'h00;
    pd_ext <= 8'h00;
    timer2_output_one_en <= 1'b0;
    timer2_output_two_en <= 1'b0;
    $display("override test done");
  endtask

  task automatic t_inbuf();
    @(posedge clk_i);
    sleep_i <= 1'b1;
    pd_dir <= 8'h00;
    pd_ext <= 8'h0f;
    settle(2);
    chk({ei1, ei0, cap, tclk}, 4'b0000);
    @(posedge clk_i);
    external_interrupt_zero_en <= 1'b1;
    pc_sel <= 8'h08;
    port_d_pin_change_group_enable <= 1'b1;
    settle(2);
    chk({ei1, ei0, cap, tclk}, 4'b1100);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    settle(2);
    chk({cap, pcs[0]}, 2'b11);
    chk({tclk, pcs}, 9'h10f);
    @(posedge clk_i);
    sleep_i <= 1'b1;
    port_d_pin_change_group_enable <= 1'b0;
    external_interrupt_zero_en <= 1'b0;
    external_interrupt_one_en <= 1'b1;
    settle(2);
    chk({ei1, ei0}, 2'b10);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    external_interrupt_one_en <= 1'b0;
    pd_ext <= 8'h00;
    $display("input buffer test done");
  endtask

  task automatic t_irq();
    wb(1'b1, POV_OFS_IRQ_MASK, 8'h01);
    wb(1'b0, POV_OFS_IRQ_STATUS, 8'h00);
    pb_ext <= 8'h01;
    settle(3);
    chk(irq_o, 1'b1);
    rdc(POV_OFS_IRQ_STATUS, 8'h01);
    settle(1);
    chk(irq_o, 1'b0);
    wb(1'b1, POV_OFS_IRQ_MASK, 8'h00);
    pb_ext <= 8'h00;
    settle(3);
    chk(irq_o, 1'b0);
    rdc(POV_OFS_IRQ_STATUS, 8'h01);
    $display("interrupt test done");
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pullup();
    t_override();
    t_inbuf();
    t_irq();
    close_out();
  end
endmodule
`default_nettype wire
